// ===== design/hbt_channel.sv
`timescale 1ns/1ps
// compare logic of one break channel, combinational
module hbt_channel #(
	parameter bit HAS_DATA = 1'b0
) (
	input wire hbt_pkg::hbt_ch_cfg_t cfg_i,
	input wire hbt_pkg::hbt_bus_t bus_i,
	output logic match_o
);
	logic addr_ok; // address condition met or not asked
	logic data_ok; // data condition met or not asked
	logic dir_ok; // direction condition met or not asked
	logic any_en; // at least one condition is asked
	logic data_use; // data compare exists and is asked

	// data compare only exists where the channel is built for it
	assign data_use = HAS_DATA && cfg_i.data_en;

	// address equality
	assign addr_ok = !cfg_i.addr_en || (bus_i.addr == cfg_i.addr);

	// data compare over the selected byte lanes
	always_comb
	begin
		data_ok = 1'b1;
		if (data_use)
		begin
			if (cfg_i.size == hbt_pkg::SIZE_UPPER)
				data_ok = bus_i.data[15:8] == cfg_i.data[15:8];
			else if (cfg_i.size == hbt_pkg::SIZE_LOWER)
				data_ok = bus_i.data[7:0] == cfg_i.data[7:0];
			else
				data_ok = bus_i.data == cfg_i.data;
		end
	end

	// read or write cycle only
	assign dir_ok = !cfg_i.dir_en || (bus_i.write == cfg_i.dir_wr);

	// a channel with nothing asked never fires
	assign any_en = cfg_i.addr_en || data_use || cfg_i.dir_en;

	// all asked conditions on the same bus cycle
	assign match_o = cfg_i.en && bus_i.valid && any_en && addr_ok && data_ok && dir_ok;
endmodule

// ===== design/hbt_pkg.sv
package hbt_pkg;
	// sizes of the block
	localparam int NUM_CH = 8;
	localparam int DATA_CH = 2;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int TRACE_DEPTH = 8;
	localparam int TPTR_W = 3;
	localparam int ST_W = 10;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0c;
	localparam logic [7:0] OFS_SWBP = 8'h10;
	localparam logic [7:0] OFS_TCNT = 8'h14;
	localparam logic [7:0] OFS_TRACE = 8'h20;
	localparam logic [7:0] OFS_CH_BASE = 8'h40;
	localparam logic [7:0] OFS_CH_END = 8'hbf;
	// offsets inside one 16-byte channel slot
	localparam logic [3:0] CH_ADDR = 4'h0;
	localparam logic [3:0] CH_CTRL = 4'h4;
	localparam logic [3:0] CH_DATA = 4'h8;
	// global control fields
	localparam int CTRL_TRACE_EN = 0;
	localparam int CTRL_TRACE_QUAL = 1;
	// command fields
	localparam int CMD_STOP = 0;
	localparam int CMD_ACC = 1;
	// status fields above the per-channel hit bits
	localparam int ST_STOP_REF = 8;
	localparam int ST_ACC_REF = 9;
	// trace count register live flags
	localparam int TCNT_FLASH = 8;
	localparam int TCNT_STEP = 9;
	// channel control fields
	localparam int CHC_EN = 0;
	localparam int CHC_ADDR_EN = 1;
	localparam int CHC_DATA_EN = 2;
	localparam int CHC_SIZE = 3;
	localparam int CHC_DIR_EN = 5;
	localparam int CHC_DIR_WR = 6;
	// access size codes
	localparam logic [1:0] SIZE_WORD = 2'h0;
	localparam logic [1:0] SIZE_UPPER = 2'h1;
	localparam logic [1:0] SIZE_LOWER = 2'h2;
	// reset values
	localparam logic [1:0] RST_CTRL = 2'h0;
	localparam logic [ST_W-1:0] RST_MASK = 10'h000;
	localparam logic [ADDR_W-1:0] RST_SWBP = 24'h000000;
	// one processor bus cycle
	typedef struct packed
	{
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} hbt_bus_t;
	// one channel's match settings
	typedef struct packed
	{
		logic en;
		logic addr_en;
		logic data_en;
		logic [1:0] size;
		logic dir_en;
		logic dir_wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} hbt_ch_cfg_t;
	localparam hbt_ch_cfg_t RST_CH_CFG = '0;
endpackage

// ===== design/hbt_top.sv
`timescale 1ns/1ps
// hardware break channels and branch trace behind an avalon slave
module hbt_top (
	input wire ref_clk_i,
	input wire rst_i,
	// avalon-mm slave
	input wire [7:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// processor bus observation
	input wire bus_valid_i,
	input wire bus_write_i,
	input wire [hbt_pkg::ADDR_W-1:0] bus_addr_i,
	input wire [hbt_pkg::DATA_W-1:0] bus_data_i,
	// processor execution state
	input wire step_active_i,
	input wire swbp_exec_i,
	input wire flash_busy_i,
	// branch trace source
	input wire br_valid_i,
	input wire [hbt_pkg::ADDR_W-1:0] br_src_i,
	// outputs to the core
	output logic brk_req_o,
	output logic stop_req_o,
	output logic dbg_acc_o,
	output logic [hbt_pkg::ADDR_W-1:0] swbp_addr_o,
	output logic irq_o
);
	hbt_pkg::hbt_bus_t bus; // bundled bus cycle
	hbt_pkg::hbt_ch_cfg_t cfg [hbt_pkg::NUM_CH]; // channel settings
	logic [hbt_pkg::NUM_CH-1:0] match; // raw channel matches
	logic [hbt_pkg::NUM_CH-1:0] hit; // matches that raise a break
	logic [1:0] ctrl; // global control
	logic [hbt_pkg::ST_W-1:0] status; // sticky events
	logic [hbt_pkg::ST_W-1:0] mask; // interrupt mask
	logic [hbt_pkg::ST_W-1:0] next_status; // status after this edge
	logic [hbt_pkg::ST_W-1:0] st_set; // events of this cycle
	logic swbp_after; // first bus cycle after a software breakpoint
	logic allow; // channel breaks permitted now
	logic trace_armed; // qualifier channel has fired
	logic trace_on; // trace capture running
	logic [hbt_pkg::ADDR_W-1:0] trace_mem [hbt_pkg::TRACE_DEPTH]; // branch sources
	logic [hbt_pkg::TPTR_W-1:0] wr_ptr; // next trace slot
	logic [hbt_pkg::TPTR_W:0] tcount; // filled trace slots
	logic req; // bus request present
	logic take_wr; // write taken this edge
	logic take_rd; // read taken this edge
	logic [31:0] rd_word; // decoded read value
	logic [31:0] wr_word; // merged write value
	logic [31:0] old_word; // current value under a write
	logic ch_sel; // address falls in channel area
	logic [7:0] ch_off; // offset from channel base
	logic [2:0] ch_idx; // addressed channel
	logic [3:0] ch_sub; // offset inside channel slot
	logic [hbt_pkg::TPTR_W-1:0] tr_idx; // addressed trace entry
	logic [hbt_pkg::TPTR_W-1:0] tr_k; // age of addressed entry

	// bundle the observed bus cycle
	assign bus = '{valid: bus_valid_i, write: bus_write_i, addr: bus_addr_i, data: bus_data_i};

	// avalon handshake terms
	assign req = avs_read_i || avs_write_i;
	assign take_wr = avs_write_i && !avs_waitrequest_o;
	assign take_rd = avs_read_i && !avs_waitrequest_o;

	// channel area decode
	assign ch_sel = (avs_address_i >= hbt_pkg::OFS_CH_BASE) && (avs_address_i <= hbt_pkg::OFS_CH_END);
	assign ch_off = avs_address_i - hbt_pkg::OFS_CH_BASE;
	assign ch_idx = ch_off[6:4];
	assign ch_sub = ch_off[3:0];

	// trace entry decode, entry zero is the newest
	assign tr_k = avs_address_i[4:2];
	assign tr_idx = wr_ptr - 3'h1 - tr_k;

	// merge write data under byte enables
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction

	// channel control word as software sees it
	function automatic logic [31:0] ctrl_word(input hbt_pkg::hbt_ch_cfg_t c);
		logic [31:0] r;
		r = 32'h00000000;
		r[hbt_pkg::CHC_EN] = c.en;
		r[hbt_pkg::CHC_ADDR_EN] = c.addr_en;
		r[hbt_pkg::CHC_DATA_EN] = c.data_en;
		r[hbt_pkg::CHC_SIZE +: 2] = c.size;
		r[hbt_pkg::CHC_DIR_EN] = c.dir_en;
		r[hbt_pkg::CHC_DIR_WR] = c.dir_wr;
		return r;
	endfunction

	// read decode, unmapped offsets read zero
	always_comb
	begin
		rd_word = 32'h00000000;
		if (avs_address_i == hbt_pkg::OFS_CTRL)
			rd_word[1:0] = ctrl;
		else if (avs_address_i == hbt_pkg::OFS_STATUS)
			rd_word[hbt_pkg::ST_W-1:0] = status;
		else if (avs_address_i == hbt_pkg::OFS_MASK)
			rd_word[hbt_pkg::ST_W-1:0] = mask;
		else if (avs_address_i == hbt_pkg::OFS_SWBP)
			rd_word[hbt_pkg::ADDR_W-1:0] = swbp_addr_o;
		else if (avs_address_i == hbt_pkg::OFS_TCNT)
		begin
			// fill level plus live execution flags
			rd_word[hbt_pkg::TPTR_W:0] = tcount;
			rd_word[hbt_pkg::TCNT_FLASH] = flash_busy_i;
			rd_word[hbt_pkg::TCNT_STEP] = step_active_i;
		end
		else if ((avs_address_i[7:5] == 3'h1) && (avs_address_i[1:0] == 2'h0))
		begin
			// trace window, unfilled entries read zero
			if ({1'b0, tr_k} < tcount)
				rd_word[hbt_pkg::ADDR_W-1:0] = trace_mem[tr_idx];
		end
		else if (ch_sel && (ch_sub == hbt_pkg::CH_ADDR))
			rd_word[hbt_pkg::ADDR_W-1:0] = cfg[ch_idx].addr;
		else if (ch_sel && (ch_sub == hbt_pkg::CH_CTRL))
			rd_word = ctrl_word(cfg[ch_idx]);
		else if (ch_sel && (ch_sub == hbt_pkg::CH_DATA))
			rd_word[hbt_pkg::DATA_W-1:0] = cfg[ch_idx].data;
	end

	// value under a write, for byte merging
	always_comb
	begin
		old_word = 32'h00000000;
		if (avs_address_i == hbt_pkg::OFS_CTRL)
			old_word[1:0] = ctrl;
		else if (avs_address_i == hbt_pkg::OFS_MASK)
			old_word[hbt_pkg::ST_W-1:0] = mask;
		else if (avs_address_i == hbt_pkg::OFS_SWBP)
			old_word[hbt_pkg::ADDR_W-1:0] = swbp_addr_o;
		else if (ch_sel && (ch_sub == hbt_pkg::CH_ADDR))
			old_word[hbt_pkg::ADDR_W-1:0] = cfg[ch_idx].addr;
		else if (ch_sel && (ch_sub == hbt_pkg::CH_CTRL))
			old_word = ctrl_word(cfg[ch_idx]);
		else if (ch_sel && (ch_sub == hbt_pkg::CH_DATA))
			old_word[hbt_pkg::DATA_W-1:0] = cfg[ch_idx].data;
	end
	assign wr_word = merge(old_word, avs_writedata_i, avs_byteenable_i);

	// waitrequest drops for one cycle after each new request
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			avs_waitrequest_o <= 1'b1;
		else
			avs_waitrequest_o <= !(req && avs_waitrequest_o);
	end

	// read data is latched while waitrequest is still high
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= rd_word;
	end

	// global control and mask registers
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			ctrl <= hbt_pkg::RST_CTRL;
			mask <= hbt_pkg::RST_MASK;
		end
		else if (take_wr && (avs_address_i == hbt_pkg::OFS_CTRL))
			ctrl <= wr_word[1:0];
		else if (take_wr && (avs_address_i == hbt_pkg::OFS_MASK))
			mask <= wr_word[hbt_pkg::ST_W-1:0];
	end

	// software breakpoint address, odd values lose bit zero
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			swbp_addr_o <= hbt_pkg::RST_SWBP;
		else if (take_wr && (avs_address_i == hbt_pkg::OFS_SWBP))
			swbp_addr_o <= {wr_word[hbt_pkg::ADDR_W-1:1], 1'b0};
	end

	// one settings register and one comparator per channel
	for (genvar g = 0; g < hbt_pkg::NUM_CH; g++)
	begin : g_ch
		// channel slot writes
		always_ff @(posedge ref_clk_i)
		begin
			if (rst_i)
				cfg[g] <= hbt_pkg::RST_CH_CFG;
			else if (take_wr && ch_sel && (ch_idx == 3'(g)))
			begin
				if (ch_sub == hbt_pkg::CH_ADDR)
					cfg[g].addr <= wr_word[hbt_pkg::ADDR_W-1:0];
				else if (ch_sub == hbt_pkg::CH_CTRL)
				begin
					cfg[g].en <= wr_word[hbt_pkg::CHC_EN];
					cfg[g].addr_en <= wr_word[hbt_pkg::CHC_ADDR_EN];
					// data enable sticks at zero without a data comparator
					cfg[g].data_en <= (g < hbt_pkg::DATA_CH) && wr_word[hbt_pkg::CHC_DATA_EN];
					cfg[g].size <= wr_word[hbt_pkg::CHC_SIZE +: 2];
					cfg[g].dir_en <= wr_word[hbt_pkg::CHC_DIR_EN];
					cfg[g].dir_wr <= wr_word[hbt_pkg::CHC_DIR_WR];
				end
				else if ((ch_sub == hbt_pkg::CH_DATA) && (g < hbt_pkg::DATA_CH))
					cfg[g].data <= wr_word[hbt_pkg::DATA_W-1:0];
			end
		end

		// comparator for this channel
		hbt_channel #(
			.HAS_DATA(g < hbt_pkg::DATA_CH)
		) u_ch (
			.cfg_i(cfg[g]),
			.bus_i(bus),
			.match_o(match[g])
		);

		// channel one as trace qualifier raises no break
		assign hit[g] = match[g] && allow && !((g == 0) && ctrl[hbt_pkg::CTRL_TRACE_QUAL]);
	end

	// marks the first bus cycle after the breakpoint instruction
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			swbp_after <= 1'b0;
		else if (swbp_exec_i)
			swbp_after <= 1'b1;
		else if (bus_valid_i)
			swbp_after <= 1'b0;
	end

	// break gating by execution state
	assign allow = !step_active_i && !swbp_exec_i && !swbp_after && !flash_busy_i;

	// break request to the core
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			brk_req_o <= 1'b0;
		else
			brk_req_o <= |hit;
	end

	// stop and debug access commands, refused during flash routine
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			stop_req_o <= 1'b0;
			dbg_acc_o <= 1'b0;
		end
		else
		begin
			stop_req_o <= take_wr && (avs_address_i == hbt_pkg::OFS_CMD)
				&& avs_byteenable_i[0] && avs_writedata_i[hbt_pkg::CMD_STOP] && !flash_busy_i;
			dbg_acc_o <= take_wr && (avs_address_i == hbt_pkg::OFS_CMD)
				&& avs_byteenable_i[0] && avs_writedata_i[hbt_pkg::CMD_ACC] && !flash_busy_i;
		end
	end

	// events of this cycle
	always_comb
	begin
		st_set = '0;
		st_set[hbt_pkg::NUM_CH-1:0] = hit;
		st_set[hbt_pkg::ST_STOP_REF] = take_wr && (avs_address_i == hbt_pkg::OFS_CMD)
			&& avs_byteenable_i[0] && avs_writedata_i[hbt_pkg::CMD_STOP] && flash_busy_i;
		st_set[hbt_pkg::ST_ACC_REF] = take_wr && (avs_address_i == hbt_pkg::OFS_CMD)
			&& avs_byteenable_i[0] && avs_writedata_i[hbt_pkg::CMD_ACC] && flash_busy_i;
	end

	// a read clears only the bits it reported, so an event landing between
	// the latch edge and the taken edge survives; a new event wins over the clear
	always_comb
	begin
		next_status = status;
		if (take_rd && (avs_address_i == hbt_pkg::OFS_STATUS))
			next_status = status & ~avs_readdata_o[hbt_pkg::ST_W-1:0];
		next_status = next_status | st_set;
	end

	// sticky status register
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			status <= '0;
		else
			status <= next_status;
	end

	// level interrupt from unmasked status
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(status & mask);
	end

	// qualifier arms trace on the first channel one match
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			trace_armed <= 1'b0;
		else if (!ctrl[hbt_pkg::CTRL_TRACE_EN] || !ctrl[hbt_pkg::CTRL_TRACE_QUAL])
			trace_armed <= 1'b0;
		else if (match[0])
			trace_armed <= 1'b1;
	end

	// capture runs free or only once qualified
	assign trace_on = ctrl[hbt_pkg::CTRL_TRACE_EN]
		&& (!ctrl[hbt_pkg::CTRL_TRACE_QUAL] || trace_armed);

	// branch source ring, the oldest entry is overwritten
	always_ff @(posedge ref_clk_i)
	begin
		if (br_valid_i && trace_on)
			trace_mem[wr_ptr] <= br_src_i;
	end

	// ring pointer and fill level
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			wr_ptr <= '0;
			tcount <= '0;
		end
		else if (br_valid_i && trace_on)
		begin
			wr_ptr <= wr_ptr + 3'h1;
			if (tcount != 4'(hbt_pkg::TRACE_DEPTH))
				tcount <= tcount + 4'h1;
		end
	end
endmodule

// ===== verif/hbt_cpu_model.sv
`timescale 1ns/1ps
// processor side: bus cycles and branch reports
module hbt_cpu_model (
	input wire ref_clk_i,
	output hbt_pkg::hbt_bus_t bus_o,
	output logic br_valid_o,
	output logic [hbt_pkg::ADDR_W-1:0] br_src_o
);
	// idle bus at start
	initial
	begin
		bus_o = '0;
		br_valid_o = 1'b0;
		br_src_o = '0;
	end
	// one bus cycle after gap idle cycles; released lines show inverted values
	task automatic cyc(input logic w, input logic [23:0] a, input logic [15:0] d, input int gap);
		repeat (gap) @(posedge ref_clk_i);
		@(posedge ref_clk_i);
		bus_o <= '{1'b1, w, a, d};
		@(posedge ref_clk_i);
		bus_o <= '{1'b0, ~w, ~a, ~d};
	endtask
	// one executed branch
	task automatic br(input logic [23:0] s);
		@(posedge ref_clk_i);
		br_valid_o <= 1'b1;
		br_src_o <= s;
		@(posedge ref_clk_i);
		br_valid_o <= 1'b0;
		br_src_o <= ~s;
	endtask
endmodule

// ===== verif/hbt_properties.sv
`timescale 1ns/1ps
// port-level checks of break gating, commands and bus timing
module hbt_properties (
	input wire ref_clk_i,
	input wire rst_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire avs_waitrequest_o,
	input wire bus_valid_i,
	input wire step_active_i,
	input wire swbp_exec_i,
	input wire flash_busy_i,
	input wire brk_req_o,
	input wire stop_req_o,
	input wire dbg_acc_o,
	input wire [hbt_pkg::ADDR_W-1:0] swbp_addr_o,
	input wire irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// set by a breakpoint instruction, cleared by the next bus cycle
	logic resume;
	// tracks the first bus cycle after a breakpoint instruction
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			resume <= 1'b0;
		else if (swbp_exec_i)
			resume <= 1'b1;
		else if (bus_valid_i)
			resume <= 1'b0;
	end
	AST_STEP_GATE: assert property (step_active_i |=> !brk_req_o)
		else $error("break raised during single step");
	AST_SWBP_GATE: assert property (swbp_exec_i |=> !brk_req_o)
		else $error("break raised at breakpoint instruction");
	AST_RESUME_GATE: assert property (resume && bus_valid_i |=> !brk_req_o)
		else $error("break raised right after resume");
	AST_FLASH_GATE: assert property (flash_busy_i |=> !brk_req_o)
		else $error("break raised during flash routine");
	AST_NO_BUS: assert property (!bus_valid_i |=> !brk_req_o)
		else $error("break raised without a bus cycle");
	AST_SWBP_EVEN: assert property (swbp_addr_o[0] == 1'b0)
		else $error("breakpoint address is odd");
	AST_STOP_PULSE: assert property (stop_req_o |-> !$past(flash_busy_i) ##1 !stop_req_o)
		else $error("stop request wrong");
	AST_ACC_PULSE: assert property (dbg_acc_o |-> !$past(flash_busy_i) ##1 !dbg_acc_o)
		else $error("debug access request wrong");
	AST_WAIT_ONE: assert property ($rose(avs_read_i | avs_write_i) |=> !avs_waitrequest_o)
		else $error("bus answer not after one wait cycle");
	AST_WAIT_BACK: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("wait low for more than one cycle");
	// main scenarios reached
	cover property (brk_req_o);
	cover property (stop_req_o);
	cover property (dbg_acc_o);
	cover property (irq_o);
endmodule

bind hbt_top hbt_properties hbt_properties_i (.ref_clk_i, .rst_i, .avs_read_i, .avs_write_i,
	.avs_waitrequest_o, .bus_valid_i, .step_active_i, .swbp_exec_i, .flash_busy_i,
	.brk_req_o, .stop_req_o, .dbg_acc_o, .swbp_addr_o, .irq_o);

// ===== verif/tb.sv
`timescale 1ns/1ps
// register-level tests of break channels, gating, irq and trace
module tb;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] adr = 8'h00; // avalon request
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic step = 1'b0; // execution state inputs
	logic swe = 1'b0;
	logic fl = 1'b0;
	hbt_pkg::hbt_bus_t bus;
	logic br_v;
	logic [23:0] br_s;
	logic [31:0] rdata;
	logic wreq, brk, stp, acc, irq;
	logic [23:0] swa;
	logic [31:0] v; // last read word
	logic [1:0] sz [3] = '{hbt_pkg::SIZE_WORD, hbt_pkg::SIZE_UPPER, hbt_pkg::SIZE_LOWER};
	logic [15:0] hd [3] = '{16'h12c4, 16'h12ff, 16'haac4}; // hitting data
	logic [15:0] md [3] = '{16'h12c5, 16'h13c4, 16'h12c5}; // missing data
	int bad_count = 0;
	int checked = 0;
	int stops = 0;
	int accs = 0;
	// the debug host side runs on the system clock itself, never a faster one
	always #12.5 ref_clk_i = ~ref_clk_i;
	// count command pulses
	always @(posedge ref_clk_i)
	begin
		if (stp === 1'b1) stops++;
		if (acc === 1'b1) accs++;
	end
	hbt_cpu_model hbt_cpu_model_i (.ref_clk_i, .bus_o(bus), .br_valid_o(br_v), .br_src_o(br_s));
	hbt_top hbt_top_i (.ref_clk_i, .rst_i, .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .bus_valid_i(bus.valid),
		.bus_write_i(bus.write), .bus_addr_i(bus.addr), .bus_data_i(bus.data),
		.step_active_i(step), .swbp_exec_i(swe), .flash_busy_i(fl), .br_valid_i(br_v),
		.br_src_i(br_s), .brk_req_o(brk), .stop_req_o(stp), .dbg_acc_o(acc),
		.swbp_addr_o(swa), .irq_o(irq));
	// compare and count
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// counts and verdict, ends the run
	task print_verdict;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one avalon access, held until waitrequest is seen low
	task acc_t(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk_i);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		n = 0;
		do
		begin
			@(posedge ref_clk_i);
			n++;
		end
		while (wreq !== 1'b0 && n < 50);
		if (n >= 50) chk("waitrequest", wreq, 0);
		v = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// read and compare
	task rd_c(input string n, input logic [7:0] a, input logic [31:0] e);
		acc_t(1'b0, a, 32'h0);
		chk(n, v, e);
	endtask
	// bus cycle then break check in the following cycle
	task hit(input logic w, input logic [23:0] a, input logic [15:0] d, input logic e);
		hbt_cpu_model_i.cyc(w, a, d, 0);
		#1 chk("brk_req", brk, e);
	endtask
	// channel register address
	function automatic logic [7:0] ca(input int n, input logic [3:0] o);
		return hbt_pkg::OFS_CH_BASE + 8'(n * 16) + 8'(o);
	endfunction
	// channel control word
	function automatic logic [31:0] cc(input logic ae, de, input logic [1:0] s, input logic re, dw);
		return {25'h0, dw, re, s, de, ae, 1'b1};
	endfunction
	// main sequence
	initial
	begin
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rd_c("ch ctrl", ca(7, hbt_pkg::CH_CTRL), 32'h0);
		rd_c("unmapped", 8'hfc, 32'h0);
		acc_t(1'b1, hbt_pkg::OFS_SWBP, 32'h123457);
		rd_c("swbp", hbt_pkg::OFS_SWBP, 32'h123456);
		chk("swbp_addr", swa, 32'h123456);
		$display("test reset and swbp done");
		for (int n = 0; n < 8; n++)
		begin
			acc_t(1'b1, ca(n, hbt_pkg::CH_ADDR), 32'h1000 + n * 16);
			acc_t(1'b1, ca(n, hbt_pkg::CH_CTRL), cc(1, 0, 0, 1, n[0]));
			hit(!n[0], 24'h1000 + n * 16, 16'h0, 1'b0);
			hit(n[0], 24'h1001 + n * 16, 16'h0, 1'b0);
			hit(n[0], 24'h1000 + n * 16, 16'h0, 1'b1);
			rd_c("status", hbt_pkg::OFS_STATUS, 32'h1 << n);
			acc_t(1'b1, ca(n, hbt_pkg::CH_CTRL), 32'h0);
		end
		$display("test channels done");
		for (int s = 0; s < 3; s++)
		begin
			acc_t(1'b1, ca(s / 2, hbt_pkg::CH_DATA), 32'h12c4);
			acc_t(1'b1, ca(s / 2, hbt_pkg::CH_CTRL), cc(0, 1, sz[s], 0, 0));
			hit(1'b0, 24'h0, md[s], 1'b0);
			hit(1'b1, 24'h0, hd[s], 1'b1);
			acc_t(1'b1, ca(s / 2, hbt_pkg::CH_CTRL), 32'h0);
		end
		acc_t(1'b0, hbt_pkg::OFS_STATUS, 32'h0);
		acc_t(1'b1, ca(2, hbt_pkg::CH_DATA), 32'hffff);
		rd_c("ch3 data", ca(2, hbt_pkg::CH_DATA), 32'h0);
		acc_t(1'b1, ca(2, hbt_pkg::CH_CTRL), cc(1, 1, 0, 0, 0));
		rd_c("ch3 ctrl", ca(2, hbt_pkg::CH_CTRL), 32'h3);
		hit(1'b0, 24'h1020, 16'h5555, 1'b1);
		$display("test data sizes done");
		@(posedge ref_clk_i) step <= 1'b1;
		hit(1'b0, 24'h1020, 16'h0, 1'b0);
		@(posedge ref_clk_i) step <= 1'b0;
		fl <= 1'b1;
		hit(1'b0, 24'h1020, 16'h0, 1'b0);
		rd_c("tcnt", hbt_pkg::OFS_TCNT, 32'h100);
		acc_t(1'b1, hbt_pkg::OFS_CMD, 32'h3);
		rd_c("status", hbt_pkg::OFS_STATUS, 32'h304);
		fl <= 1'b0;
		acc_t(1'b1, hbt_pkg::OFS_CMD, 32'h3);
		repeat (3) @(posedge ref_clk_i);
		chk("stops", stops, 1);
		chk("accesses", accs, 1);
		@(posedge ref_clk_i) swe <= 1'b1;
		@(posedge ref_clk_i) swe <= 1'b0;
		hit(1'b0, 24'h1020, 16'h0, 1'b0);
		hit(1'b0, 24'h1020, 16'h0, 1'b1);
		$display("test gating done");
		rd_c("status", hbt_pkg::OFS_STATUS, 32'h4);
		acc_t(1'b1, hbt_pkg::OFS_MASK, 32'h8);
		acc_t(1'b1, ca(3, hbt_pkg::CH_CTRL), cc(1, 0, 0, 0, 0));
		hit(1'b0, 24'h1030, 16'h0, 1'b1);
		@(posedge ref_clk_i) #1 chk("irq", irq, 1);
		rd_c("status", hbt_pkg::OFS_STATUS, 32'h8);
		hit(1'b0, 24'h1020, 16'h0, 1'b1);
		@(posedge ref_clk_i) #1 chk("irq", irq, 0);
		$display("test irq done");
		acc_t(1'b1, hbt_pkg::OFS_CTRL, 32'h1);
		for (int k = 0; k < 10; k++) hbt_cpu_model_i.br(24'h200 + 2 * k);
		rd_c("tcnt", hbt_pkg::OFS_TCNT, 32'h8);
		for (int k = 0; k < 8; k++)
			rd_c("trace", hbt_pkg::OFS_TRACE + 8'(4 * k), 32'h200 + 2 * (9 - k));
		acc_t(1'b1, hbt_pkg::OFS_CTRL, 32'h3);
		acc_t(1'b1, ca(0, hbt_pkg::CH_CTRL), cc(1, 0, 0, 0, 0));
		hbt_cpu_model_i.br(24'h300);
		rd_c("trace", hbt_pkg::OFS_TRACE, 32'h212);
		hit(1'b0, 24'h1000, 16'h0, 1'b0);
		hbt_cpu_model_i.br(24'h302);
		rd_c("trace", hbt_pkg::OFS_TRACE, 32'h302);
		$display("test trace done");
		// reset in mid-run, the host keeps its start-up clock afterwards
		@(posedge ref_clk_i) rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rd_c("ctrl", hbt_pkg::OFS_CTRL, 32'h0);
		rd_c("tcnt", hbt_pkg::OFS_TCNT, 32'h0);
		rd_c("ch1 ctrl", ca(0, hbt_pkg::CH_CTRL), 32'h0);
		chk("swbp_addr", swa, 32'h0);
		chk("brk_req", brk, 32'h0);
		$display("test mid-run reset done");
		print_verdict;
	end
	// watchdog far beyond the expected run length
	initial
	begin
		repeat (8000) @(posedge ref_clk_i);
		bad_count++;
		print_verdict;
	end
endmodule
